// *** hdl/hct_regs.svh ***
// Contract
// - Reg 05 resets to 4A on any reset.
// - Host-timeout field: off, 40s, 80s, 160s.
// - Safety length: 3h, 5h, 8h, 12h when enabled.
// - Reg 06 resets to 0B on any reset.
// - Switch-off bit opens the battery switch.
// - Junction limit field: 60, 80, 100, 120 C.
// - Status register read-only, cleared only at power-on.
// - Charge phase field reports charger state.
// - Power-path bit shows input limiting.
// - Power-good bit shows valid input.
// - Thermal-regulation bit shows current foldback.
// - Fault register read-only; bit 6 clears on a kick, bit 2 when the safety timer is disabled.
// - Fault bit 6 marks host-timeout expiry.
// - Fault bit 5 marks input fault.
// - Fault bit 4 marks thermal shutdown.
// - Fault bit 3 marks battery overvoltage.
// - Fault bit 2 marks safety timer expiry.
// - Fault bit 1 marks thermistor hot.
// - Fault bit 0 marks thermistor cold.
// - Host-timeout counter holds without input power.
`ifndef HCT_REGS_SVH
`define HCT_REGS_SVH
`define HCT_OFS_POC     8'h01
`define HCT_OFS_TTC     8'h05
`define HCT_OFS_MISC    8'h06
`define HCT_OFS_STAT    8'h07
`define HCT_OFS_FLT     8'h08
`define HCT_TTC_RST     8'h4A
`define HCT_MISC_RST    8'h0B
`define HCT_POC_RSTCMD  7
`define HCT_POC_KICK    6
`define HCT_WD_40S      8'h28
`define HCT_WD_80S      8'h50
`define HCT_WD_160S     8'hA0
`define HCT_SF_3H_S     16'h2A30
`define HCT_SF_5H_S     16'h4650
`define HCT_SF_8H_S     16'h7080
`define HCT_SF_12H_S    16'hA8C0
`define HCT_SEC_NS      32'h3B9ACA00
`define HCT_CLK_NS      32'h4
`define HCT_ACK_BIT     4'h8
`define HCT_LAST_BIT    4'h7
`define HCT_START_BITS  4'h3
`endif

// *** hdl/hct_pkg.sv ***
package hct_pkg;
  typedef struct packed {
    logic       rsvd7;
    logic       term_enable;
    logic [1:0] host_timeout_sel;
    logic       safety_timer_enable;
    logic [1:0] safety_timer_length;
    logic       termination_timer_enable;
  } hct_ttc_s;
  typedef struct packed {
    logic [1:0] rsvd76;
    logic       battery_switch_off;
    logic       rsvd4;
    logic       thermistor_monitor_enable;
    logic       rsvd2;
    logic [1:0] junction_temp_limit;
  } hct_misc_s;
  typedef struct packed {
    logic [1:0] charge_phase;
    logic       power_path_active;
    logic       input_power_good;
    logic       thermal_regulation_active;
    logic       input_fault;
    logic       thermal_shutdown_flag;
    logic       battery_overvoltage_flag;
    logic       thermistor_hot;
    logic       thermistor_cold;
  } hct_sense_s;
  typedef struct packed {
    logic [7:0] ofs;
    logic [7:0] data;
  } hct_wr_s;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA} hct_phase_e;
endpackage

// *** hdl/hct_bank.sv ***
`timescale 1ns/1ps
`include "hct_regs.svh"
module hct_bank #(
  parameter logic [6:0] DEV_ADDR    = 7'h09,
  // Revision code; the value is arbitrary.
  parameter logic [1:0] REV         = 2'h1,
  parameter int         TICK_CYCLES = `HCT_SEC_NS / `HCT_CLK_NS
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic              SCL_CLK,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE,
  input  wire hct_pkg::hct_sense_s SENSE,
  output hct_pkg::hct_ttc_s      CTRL_TTC,
  output hct_pkg::hct_misc_s     CTRL_MISC,
  output logic                   HOST_TIMEOUT_EVENT,
  output logic                   SAFETY_TIMER_FAULT
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                scl1;
    logic                scl2;
    logic                sda1;
    logic                sda2;
    logic                sda_p;
    logic                st_tog;
    logic                wr1;
    logic                wr2;
    logic                wr_p;
    logic                ack1;
    logic                ack2;
    logic                req;
    logic [31:0]         img;
    hct_pkg::hct_sense_s sn1;
    hct_pkg::hct_sense_s sn2;
    hct_pkg::hct_ttc_s   ttc;
    hct_pkg::hct_misc_s  misc;
    logic [7:0]          stat;
    logic [7:0]          flt;
    logic [27:0]         tick;
    logic [7:0]          wd_sec;
    logic [15:0]         sf_sec;
  } hct_core_s;

  typedef struct packed {
    logic                r1;
    logic                r2;
    logic                st1;
    logic                st2;
    logic                st_p;
    logic                rq1;
    logic                rq2;
    logic                rq_p;
    logic                ack;
    logic [31:0]         img;
    hct_pkg::hct_phase_e ph;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic [7:0]          ptr;
    logic [7:0]          tx;
    logic                first;
    logic                pull;
    logic                wr_tog;
    hct_pkg::hct_wr_s    wr;
  } hct_link_s;

  hct_core_s  c_q;
  hct_core_s  c_d;
  hct_link_s  l_q;
  hct_link_s  l_d;
  logic       oe_q;
  logic       sda_o_q;
  logic       wr_ev;
  logic       tick_ev;
  logic       wd_en;
  logic       wd_exp;
  logic       kick;
  logic       regrst;
  logic       charging;
  logic [7:0] wd_lim;
  logic [15:0] sf_lim;
  logic [7:0] byte_in;
  logic [7:0] nxt_ptr;

  function automatic logic [7:0] wd_limit(input logic [1:0] sel);
    unique case (sel)
      2'h1:    return `HCT_WD_40S;
      2'h2:    return `HCT_WD_80S;
      2'h3:    return `HCT_WD_160S;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [15:0] sf_limit(input logic [1:0] len);
    unique case (len)
      2'h0: return `HCT_SF_3H_S;
      2'h1: return `HCT_SF_5H_S;
      2'h2: return `HCT_SF_8H_S;
      2'h3: return `HCT_SF_12H_S;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input logic [31:0] img);
    unique case (ofs)
      `HCT_OFS_TTC:  return img[7:0];
      `HCT_OFS_MISC: return img[15:8];
      `HCT_OFS_STAT: return img[23:16];
      `HCT_OFS_FLT:  return img[31:24];
      default:       return 8'h00;
    endcase
  endfunction

  // ************************************************************
  // Core domain: register bank and timers
  // ************************************************************
  always_comb
  begin
    wr_ev    = c_q.wr2 != c_q.wr_p;
    tick_ev  = c_q.tick == 28'(TICK_CYCLES - 1);
    wd_lim   = wd_limit(c_q.ttc.host_timeout_sel);
    sf_lim   = sf_limit(c_q.ttc.safety_timer_length);
    wd_en    = c_q.ttc.host_timeout_sel != 2'h0;
    wd_exp   = wd_en && (c_q.wd_sec >= wd_lim);
    kick     = wr_ev && l_q.wr.ofs == `HCT_OFS_POC && l_q.wr.data[`HCT_POC_KICK];
    regrst   = wr_ev && l_q.wr.ofs == `HCT_OFS_POC && l_q.wr.data[`HCT_POC_RSTCMD];
    charging = c_q.sn2.charge_phase[1] ^ c_q.sn2.charge_phase[0];
    c_d      = c_q;
    // SCL and SDA are watched here only to spot START; bit timing lives on SCL.
    c_d.scl1  = SCL_CLK;
    c_d.scl2  = c_q.scl1;
    c_d.sda1  = SDA_I;
    c_d.sda2  = c_q.sda1;
    c_d.sda_p = c_q.sda2;
    if (c_q.scl2 && c_q.sda_p && !c_q.sda2)
    begin
      c_d.st_tog = !c_q.st_tog;
    end
    c_d.wr1  = l_q.wr_tog;
    c_d.wr2  = c_q.wr1;
    c_d.wr_p = c_q.wr2;
    c_d.ack1 = l_q.ack;
    c_d.ack2 = c_q.ack1;
    c_d.sn1  = SENSE;
    c_d.sn2  = c_q.sn1;
    c_d.tick = tick_ev ? 28'h0 : c_q.tick + 28'h1;
    // The write word is held by the link until its next byte, long after this sees it.
    if (wr_ev)
    begin
      unique case (l_q.wr.ofs)
        `HCT_OFS_TTC:  c_d.ttc = l_q.wr.data;
        `HCT_OFS_MISC: c_d.misc = l_q.wr.data;
        default:       c_d.ttc = c_q.ttc;
      endcase
    end
    if (!wd_en || kick || wd_exp)
    begin
      c_d.wd_sec = 8'h00;
    end
    else if (c_q.sn2.input_power_good && tick_ev)
    begin
      c_d.wd_sec = c_q.wd_sec + 8'h01;
    end
    // Expiry reloads the timeout select to off, so the watchdog stays idle until rearmed.
    if (wd_exp || regrst)
    begin
      c_d.ttc  = `HCT_TTC_RST;
      c_d.misc = `HCT_MISC_RST;
    end
    if (!c_q.ttc.safety_timer_enable || !charging)
    begin
      c_d.sf_sec = 16'h0000;
    end
    else if (tick_ev && c_q.sf_sec < sf_lim)
    begin
      c_d.sf_sec = c_q.sf_sec + 16'h0001;
    end
    c_d.stat = {1'b0, REV, c_q.sn2.charge_phase,
                c_q.sn2.power_path_active,
                c_q.sn2.input_power_good,
                c_q.sn2.thermal_regulation_active};
    if (kick)
    begin
      c_d.flt[6] = 1'b0;
    end
    if (wd_exp)
    begin
      c_d.flt[6] = 1'b1;
    end
    c_d.flt[7] = 1'b0;
    c_d.flt[5] = c_q.sn2.input_fault;
    c_d.flt[4] = c_q.sn2.thermal_shutdown_flag;
    c_d.flt[3] = c_q.sn2.battery_overvoltage_flag;
    if (!c_q.ttc.safety_timer_enable)
    begin
      c_d.flt[2] = 1'b0;
    end
    else if (charging && c_q.sf_sec >= sf_lim)
    begin
      c_d.flt[2] = 1'b1;
    end
    c_d.flt[1] = c_q.sn2.thermistor_hot && c_q.misc.thermistor_monitor_enable;
    c_d.flt[0] = c_q.sn2.thermistor_cold && c_q.misc.thermistor_monitor_enable;
    if (c_q.ack2 == c_q.req)
    begin
      c_d.img = {c_q.flt, c_q.stat, c_q.misc, c_q.ttc};
      c_d.req = !c_q.req;
    end
  end

  // Status and fault clear here; a kick also clears fault bit 6, and disabling the safety timer clears bit 2.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      c_q      <= '0;
      c_q.ttc  <= `HCT_TTC_RST;
      c_q.misc <= `HCT_MISC_RST;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  assign CTRL_TTC           = c_q.ttc;
  assign CTRL_MISC          = c_q.misc;
  assign HOST_TIMEOUT_EVENT = c_q.flt[6];
  assign SAFETY_TIMER_FAULT = c_q.flt[2];

  // ************************************************************
  // Link domain: serial engine on SCL
  // ************************************************************
  always_comb
  begin
    byte_in = {l_q.sh[6:0], SDA_I};
    nxt_ptr = l_q.first ? l_q.ptr : l_q.ptr + 8'h01;
    l_d     = l_q;
    l_d.r1  = RST_N;
    l_d.r2  = l_q.r1;
    l_d.st1 = c_q.st_tog;
    l_d.st2 = l_q.st1;
    l_d.st_p = l_q.st2;
    l_d.rq1 = c_q.req;
    l_d.rq2 = l_q.rq1;
    l_d.rq_p = l_q.rq2;
    if (l_q.rq2 != l_q.rq_p)
    begin
      l_d.img = c_q.img;
      l_d.ack = l_q.rq2;
    end
    l_d.sh   = byte_in;
    l_d.cnt  = (l_q.cnt == `HCT_ACK_BIT) ? 4'h0 : l_q.cnt + 4'h1;
    l_d.pull = 1'b0;
    // START reaches here three edges late; the shifter already holds those bits.
    if (!l_q.r2)
    begin
      l_d.ph = hct_pkg::PH_IDLE;
    end
    else if (l_q.st2 != l_q.st_p)
    begin
      l_d.ph  = hct_pkg::PH_ADDR;
      l_d.cnt = `HCT_START_BITS;
    end
    else if (l_q.ph != hct_pkg::PH_IDLE && l_q.cnt == `HCT_LAST_BIT)
    begin
      unique case (l_q.ph)
        hct_pkg::PH_ADDR:
        begin
          l_d.first = byte_in[0];
          l_d.pull  = byte_in[7:1] == DEV_ADDR;
          if (byte_in[7:1] != DEV_ADDR)
          begin
            l_d.ph = hct_pkg::PH_IDLE;
          end
          else
          begin
            l_d.ph = byte_in[0] ? hct_pkg::PH_RDATA : hct_pkg::PH_PTR;
          end
        end
        hct_pkg::PH_PTR:
        begin
          l_d.ptr  = byte_in;
          l_d.pull = 1'b1;
          l_d.ph   = hct_pkg::PH_WDATA;
        end
        hct_pkg::PH_WDATA:
        begin
          l_d.wr     = {l_q.ptr, byte_in};
          l_d.wr_tog = !l_q.wr_tog;
          l_d.ptr    = l_q.ptr + 8'h01;
          l_d.pull   = 1'b1;
        end
        default:
        begin
          l_d.pull = 1'b0;
        end
      endcase
    end
    else if (l_q.ph == hct_pkg::PH_RDATA && l_q.cnt == `HCT_ACK_BIT)
    begin
      if (l_q.first || !SDA_I)
      begin
        l_d.first = 1'b0;
        l_d.ptr   = nxt_ptr;
        l_d.tx    = rd_byte(nxt_ptr, l_q.img);
        l_d.pull  = !l_d.tx[7];
      end
      else
      begin
        l_d.ph = hct_pkg::PH_IDLE;
      end
    end
    else if (l_q.ph == hct_pkg::PH_RDATA)
    begin
      l_d.tx   = {l_q.tx[6:0], 1'b0};
      l_d.pull = !l_q.tx[6];
    end
    // Link state has no other reset; the acknowledge follows the request so the
    // snapshot handshake cannot stall, and the shifter keeps bits of an early START.
    if (!l_q.r2)
    begin
      l_d.ph     = hct_pkg::PH_IDLE;
      l_d.cnt    = 4'h0;
      l_d.first  = 1'b0;
      l_d.pull   = 1'b0;
      l_d.wr_tog = 1'b0;
      l_d.wr     = '0;
      l_d.ptr    = 8'h00;
      l_d.tx     = 8'h00;
      l_d.ack    = l_q.rq2;
      l_d.img    = c_q.img;
    end
  end

  always_ff @(posedge SCL_CLK)
  begin
    l_q <= l_d;
  end

  // SDA changes only while SCL is low.
  always_ff @(negedge SCL_CLK)
  begin
    oe_q    <= l_q.pull && l_q.r2;
    sda_o_q <= 1'b0;
  end

  assign SDA_OE = oe_q;
  assign SDA_O  = sda_o_q;

  // ************************************************************
  // Checks
  // ************************************************************
  defaults_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> c_q.ttc == `HCT_TTC_RST && c_q.misc == `HCT_MISC_RST)
    else $error("control defaults missing after reset");

  reload_on_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wd_exp || regrst) |=> c_q.ttc == `HCT_TTC_RST && c_q.misc == `HCT_MISC_RST)
    else $error("control registers not reloaded");

  wd_period_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wd_en |-> c_q.wd_sec <= wd_lim)
    else $error("host timeout counter beyond its period");

  wd_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wd_en && !c_q.sn2.input_power_good && !wr_ev && !wd_exp) |=> $stable(c_q.wd_sec))
    else $error("host timeout advanced without input power");

  wd_fault_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wd_exp |=> HOST_TIMEOUT_EVENT ##1 (HOST_TIMEOUT_EVENT || $past(kick)))
    else $error("host timeout fault not raised");

  status_map_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    1'b1 |=> c_q.stat == {1'b0, REV, $past(c_q.sn2[9:5])})
    else $error("status register does not follow charger state");

  write_apply_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_ev && l_q.wr.ofs == `HCT_OFS_MISC && !wd_exp && !regrst)
    |=> c_q.misc == $past(l_q.wr.data))
    else $error("control write not applied");

  sf_fault_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (c_q.ttc.safety_timer_enable && charging && c_q.sf_sec >= sf_lim)
    |=> SAFETY_TIMER_FAULT)
    else $error("safety timer fault not raised");

  fault_map_a: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    c_q.sn2.input_fault |=> c_q.flt[5] ##1 (c_q.flt[5] == $past(c_q.sn2.input_fault)))
    else $error("input fault bit does not follow input");

endmodule

// *** tb/hct_host.sv ***
`timescale 1ns/1ps
module hct_host #(
  parameter logic [6:0] ADDR = 7'h09
) (
  input  wire logic SDA,
  output logic      SCL,
  output logic      SDA_LOW
);
  logic [7:0] rbuf [0:7];
  logic       acked;

  // SCL stands high between frames; a released SDA floats up through the pull-up.
  initial
  begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end

  task automatic idle_clocks();
    repeat (4)
    begin
      #40 SCL = 1'b0;
      #40 SCL = 1'b1;
    end
  endtask

  task automatic bit_io(input logic b, output logic v);
    #5 SDA_LOW = ~b;
    #35 SCL = 1'b1;
    v = SDA;
    #40 SCL = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] r,
                         output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], v);
      r[i] = v;
    end
    bit_io(nak, v);
    ack = ~v;
  endtask

  task automatic start();
    SDA_LOW = 1'b0;
    #20 SCL = 1'b1;
    #40 SDA_LOW = 1'b1;
    #40 SCL = 1'b0;
  endtask

  task automatic stop();
    #5 SDA_LOW = 1'b1;
    #35 SCL = 1'b1;
    #40 SDA_LOW = 1'b0;
    #40;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    input int n);
    logic [7:0] r;
    logic       k;
    start();
    byte_io({a, 1'b0}, 1'b1, r, acked);
    byte_io(p, 1'b1, r, k);
    acked &= k;
    for (int i = 0; i < n; i++)
    begin
      byte_io(d[15-8*i -: 8], 1'b1, r, k);
      acked &= k;
    end
    stop();
  endtask

  task automatic rd(input logic [7:0] p, input int n);
    logic k;
    wr(ADDR, p, 16'h0000, 0);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, rbuf[0], k);
    for (int i = 0; i < n; i++)
      byte_io(8'hFF, (i == n - 1), rbuf[i], k);
    stop();
  endtask
endmodule

// *** tb/charger_timer_status_regs_test.sv ***
`timescale 1ns/1ps
module charger_timer_status_regs_test;
  localparam logic [6:0] ADDR = 7'h09;
  // Revision code; the value is arbitrary.
  localparam logic [1:0] REV  = 2'h1;
  logic                core_clk;
  logic                rst_n;
  logic                scl;
  logic                host_low;
  logic                sda_o;
  logic                sda_oe;
  logic                sda;
  logic                hte;
  logic                stf;
  logic                ntc_en;
  hct_pkg::hct_sense_s sense;
  hct_pkg::hct_ttc_s   ttc;
  hct_pkg::hct_misc_s  misc;
  int                  fail_count;
  int                  checks_done;
  int                  cycles;

  assign sda = ~(host_low | (sda_oe & ~sda_o));

  hct_bank #(.DEV_ADDR(ADDR), .REV(REV), .TICK_CYCLES(10)) u_hct_bank (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SCL_CLK(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SENSE(sense), .CTRL_TTC(ttc), .CTRL_MISC(misc),
    .HOST_TIMEOUT_EVENT(hte), .SAFETY_TIMER_FAULT(stf));

  hct_host #(.ADDR(ADDR)) u_hct_host (.SDA(sda), .SCL(scl), .SDA_LOW(host_low));

  always #2 core_clk = ~core_clk;

  // ****************************************
  // Checking helpers
  // ****************************************
  function automatic logic [7:0] stat_exp(input hct_pkg::hct_sense_s s);
    return {1'b0, REV, s.charge_phase, s.power_path_active, s.input_power_good,
            s.thermal_regulation_active};
  endfunction

  function automatic logic [7:0] flt_exp(input hct_pkg::hct_sense_s s, input logic en,
                                         input logic wd);
    return {1'b0, wd, s.input_fault, s.thermal_shutdown_flag, s.battery_overvoltage_flag,
            1'b0, s.thermistor_hot & en, s.thermistor_cold & en};
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The whole run needs about 40000 cycles; this ceiling only catches a hang.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fail_count++;
      $display("timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] v;
    logic [7:0] w;
    hct_pkg::hct_sense_s s;
    core_clk = 1'b0;
    rst_n = 1'b0;
    sense = '0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    ntc_en = 1'b1;
    void'($urandom(32'h835D40D4));
    u_hct_host.idle_clocks();
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    check("ctrl05 port", 8'h4A, ttc);
    check("ctrl06 port", 8'h0B, misc);
    u_hct_host.rd(8'h05, 4);
    check("reg05", 8'h4A, u_hct_host.rbuf[0]);
    check("reg06", 8'h0B, u_hct_host.rbuf[1]);
    check("reg07", stat_exp(sense), u_hct_host.rbuf[2]);
    check("reg08", 8'h00, u_hct_host.rbuf[3]);
    $display("test reset values done");

    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom);
      w = (i == 7) ? 8'hFF : 8'($urandom);
      v[5:4] = 2'b00;
      if (i < 4)
      begin
        v[2:1] = 2'(i);
        w[1:0] = 2'(i);
      end
      u_hct_host.wr(ADDR, 8'h05, {v, w}, 2);
      check("write ack", 8'h01, {7'h00, u_hct_host.acked});
      check("ctrl05 port", v, ttc);
      check("ctrl06 port", w, misc);
      u_hct_host.rd(8'h05, 2);
      check("reg05", v, u_hct_host.rbuf[0]);
      check("reg06", w, u_hct_host.rbuf[1]);
    end
    $display("test control writes done");

    u_hct_host.wr(ADDR, 8'h07, 16'h55AA, 2);
    u_hct_host.wr(ADDR, 8'h01, 16'h8000, 1);
    check("ctrl05 port", 8'h4A, ttc);
    check("ctrl06 port", 8'h0B, misc);
    u_hct_host.wr(7'h0A, 8'h05, 16'h0000, 1);
    check("wrong address ack", 8'h00, {7'h00, u_hct_host.acked});
    check("ctrl05 port", 8'h4A, ttc);
    u_hct_host.rd(8'h07, 2);
    check("reg07", stat_exp(sense), u_hct_host.rbuf[0]);
    check("reg08", 8'h00, u_hct_host.rbuf[1]);
    u_hct_host.rd(8'h20, 1);
    check("unmapped", 8'h00, u_hct_host.rbuf[0]);
    $display("test refusals done");

    for (int i = 0; i < 12; i++)
    begin
      if (i == 6)
      begin
        u_hct_host.wr(ADDR, 8'h06, 16'h0300, 1);
        ntc_en = 1'b0;
      end
      @(posedge core_clk);
      s = 10'($urandom);
      if (i < 4)
        s.charge_phase = 2'(i);
      sense <= s;
      repeat (8) @(posedge core_clk);
      u_hct_host.rd(8'h07, 2);
      check("status", stat_exp(sense), u_hct_host.rbuf[0]);
      check("fault", flt_exp(sense, ntc_en, 1'b0), u_hct_host.rbuf[1]);
      check("safety fault", 8'h00, {7'h00, stf});
    end
    $display("test status and faults done");

    @(posedge core_clk);
    sense <= '0;
    u_hct_host.wr(ADDR, 8'h05, 16'h5A00, 1);
    repeat (600) @(posedge core_clk);
    check("timeout event", 8'h00, {7'h00, hte});
    sense.input_power_good <= 1'b1;
    repeat (500) @(posedge core_clk);
    check("timeout event", 8'h01, {7'h00, hte});
    check("ctrl05 port", 8'h4A, ttc);
    check("ctrl06 port", 8'h0B, misc);
    u_hct_host.wr(ADDR, 8'h01, 16'h8000, 1);
    u_hct_host.rd(8'h07, 2);
    check("status", stat_exp(sense), u_hct_host.rbuf[0]);
    check("fault", flt_exp(sense, 1'b1, 1'b1), u_hct_host.rbuf[1]);
    u_hct_host.wr(ADDR, 8'h01, 16'h4000, 1);
    u_hct_host.rd(8'h08, 1);
    check("fault", flt_exp(sense, 1'b1, 1'b0), u_hct_host.rbuf[0]);
    $display("test host timeout done");
    finish_test();
  end
endmodule
